// ### design/dsp_pkg.sv
// Purpose: constants shared by the strobe, mask and reset pin block
// Assumes: x16 data bus with two byte lanes, core clock 20 MHz
// Notes:   link signals are sampled, not clocked, by the core clock
package dsp_pkg;
   localparam int DATA_W        = 16;
   localparam int LANES         = 2;
   localparam int LANE_W        = 8;
   localparam int SYNC_STAGES   = 2;
   localparam int TERM_BIT      = 11;   // mode_reg_one strobe-termination select
   localparam int BURST_BEATS   = 8;
   localparam int BEAT_W        = 3;
   localparam int MEM_DEPTH     = 16;
   localparam int MEM_AW        = 4;
   localparam logic [15:0] MODE_RESET = 16'h0000;
endpackage : dsp_pkg

// ### design/dsp_beat_mem.sv
// Purpose: small byte-lane data store for written beats
// Assumes: one write port with per-lane enables, registered read
// Notes:   contents are not cleared by reset, as in a real array
`timescale 1ns/1ns
`default_nettype none
module dsp_beat_mem (
   // clock
   input  wire logic                        core_clk,
   // write side
   input  wire logic [dsp_pkg::MEM_AW-1:0]  wrAddr,
   input  wire logic [dsp_pkg::LANES-1:0]   wrLaneEn,
   input  wire logic [dsp_pkg::DATA_W-1:0]  wrData,
   // read side
   input  wire logic [dsp_pkg::MEM_AW-1:0]  rdAddr,
   output var  logic [dsp_pkg::DATA_W-1:0]  rdData
);
   logic [dsp_pkg::DATA_W-1:0] store [dsp_pkg::MEM_DEPTH];

   // one process writes every lane, so the array keeps a single driver
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < dsp_pkg::LANES; i++) begin
         if (wrLaneEn[i]) begin
            store[wrAddr][i*dsp_pkg::LANE_W +: dsp_pkg::LANE_W] <=
               wrData[i*dsp_pkg::LANE_W +: dsp_pkg::LANE_W];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      rdData <= store[rdAddr];
   end
endmodule : dsp_beat_mem
`default_nettype wire

// ### design/dsp_pins.sv
// Purpose: pin behaviour of the memory data, strobe, mask and clear inputs
// Assumes: strobe and mask pins sampled by core_clk through two flops
// Notes:   termination and drive are reported as enables; the bench resolves wires
`timescale 1ns/1ns
`default_nettype none
module dsp_pins (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic                        clearPin_n,
   // mode configuration
   input  wire logic [15:0]                 modeRegOne,
   input  wire logic                        termEnabled,
   input  wire logic                        dieTerminationCtl,
   // command side
   input  wire logic                        readReq,
   input  wire logic                        writeReq,
   input  wire logic [dsp_pkg::MEM_AW-1:0]  burstAddr,
   // data pins
   input  wire logic [dsp_pkg::DATA_W-1:0]  dataIn,
   output logic      [dsp_pkg::DATA_W-1:0]  dataOut,
   output logic      [dsp_pkg::DATA_W-1:0]  dataOe_n,
   // strobe pins, true and complement per lane
   input  wire logic [dsp_pkg::LANES-1:0]   strobeIn,
   input  wire logic [dsp_pkg::LANES-1:0]   strobeCompIn,
   output logic      [dsp_pkg::LANES-1:0]   strobeOut,
   output logic      [dsp_pkg::LANES-1:0]   strobeCompOut,
   output logic      [dsp_pkg::LANES-1:0]   strobeOe_n,
   // mask and term strobe shared pin
   input  wire logic [dsp_pkg::LANES-1:0]   writeBeatMask,
   output logic                             termStrobeTermEn,
   output logic                             termStrobeCompUsed,
   // termination enables
   output logic                             dataTermEn,
   output logic                             inputPinTermEn,
   // status
   output logic                             inReset,
   output logic                             strobeFault
);
   // ----------------------------------------
   // reset condition
   // ----------------------------------------
   // clear pin is async: it gates inReset and the drive and termination enables combinationally, and is also
   // synchronised so the held state releases cleanly on the core clock
   // a low pulse that meets no edge only blanks the pins; state is kept
   logic clrMeta_reg;
   logic clrSync_reg;
   always_ff @(posedge core_clk) begin
      if (!clearPin_n) begin
         clrMeta_reg <= 1'b0;
         clrSync_reg <= 1'b0;
      end else begin
         clrMeta_reg <= 1'b1;
         clrSync_reg <= clrMeta_reg;
      end
   end
   wire inClear = !clearPin_n || !clrSync_reg || !rst_n;
   assign inReset = inClear;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [dsp_pkg::LANES-1:0]  stbMeta_reg, stb_reg, stbPrev_reg;
   logic [dsp_pkg::LANES-1:0]  stbcMeta_reg, stbc_reg;
   logic [dsp_pkg::LANES-1:0]  mskMeta_reg, msk_reg;
   logic [dsp_pkg::DATA_W-1:0] datMeta_reg, dat_reg;
   always_ff @(posedge core_clk) begin
      stbMeta_reg  <= strobeIn;
      stb_reg      <= stbMeta_reg;
      stbPrev_reg  <= stb_reg;
      stbcMeta_reg <= strobeCompIn;
      stbc_reg     <= stbcMeta_reg;
      mskMeta_reg  <= writeBeatMask;
      msk_reg      <= mskMeta_reg;
      datMeta_reg  <= dataIn;
      dat_reg      <= datMeta_reg;
   end

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } dsp_state_t;
   dsp_state_t state_reg, state_next;
   logic [dsp_pkg::BEAT_W-1:0] beat_reg, beat_next;
   logic                       phase_reg;

   wire lastBeat  = (beat_reg == dsp_pkg::BEAT_W'(dsp_pkg::BURST_BEATS - 1));
   wire stbEdge   = |(stb_reg ^ stbPrev_reg);              // both edges count
   wire writeBeat = (state_reg == ST_WRITE) && stbEdge;

   always_comb begin
      state_next = state_reg;
      beat_next  = beat_reg;
      unique case (state_reg)
         ST_IDLE: begin
            beat_next = '0;
            if (readReq) begin
               state_next = ST_READ;
            end else if (writeReq) begin
               state_next = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (writeBeat) begin
               beat_next = beat_reg + 1'b1;
               if (lastBeat) begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_READ: begin
            if (phase_reg) begin
               beat_next = beat_reg + 1'b1;
               if (lastBeat) begin
                  state_next = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (inClear) begin
         state_reg <= ST_IDLE;
         beat_reg  <= '0;
         phase_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         beat_reg  <= beat_next;
         phase_reg <= (state_reg == ST_READ) ? !phase_reg : 1'b0;
      end
   end

   // ----------------------------------------
   // write path with masking
   // ----------------------------------------
   wire termMode = modeRegOne[dsp_pkg::TERM_BIT];
   // in termination-strobe mode the shared pin is not a mask
   wire [dsp_pkg::LANES-1:0] laneKeep = termMode ? '1 : ~msk_reg;
   wire [dsp_pkg::LANES-1:0] laneWr   = writeBeat ? laneKeep : '0;
   wire [dsp_pkg::MEM_AW-1:0] wAddr = burstAddr + dsp_pkg::MEM_AW'(beat_reg);
   wire [dsp_pkg::MEM_AW-1:0] rAddr = burstAddr + dsp_pkg::MEM_AW'(beat_next);
   logic [dsp_pkg::DATA_W-1:0] memRd;

   dsp_beat_mem uMem (
      .core_clk (core_clk),
      .wrAddr   (wAddr),
      .wrLaneEn (laneWr),
      .wrData   (dat_reg),
      .rdAddr   (rAddr),
      .rdData   (memRd)
   );

   // ----------------------------------------
   // read drive
   // ----------------------------------------
   // strobe toggles every cycle of a read, two edges per two-cycle beat, so each data change meets an edge
   logic [dsp_pkg::DATA_W-1:0] dOut_reg;
   logic                       stbLvl_reg;
   logic                       driving_reg;
   always_ff @(posedge core_clk) begin
      if (inClear) begin
         dOut_reg    <= '0;
         stbLvl_reg  <= 1'b0;
         driving_reg <= 1'b0;
      end else begin
         driving_reg <= (state_reg == ST_READ);
         stbLvl_reg  <= (state_reg == ST_READ) ? !stbLvl_reg : 1'b0;
         dOut_reg    <= memRd;
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   // the clear pin cuts the drive at once, not one edge later
   wire driveNow = driving_reg && !inClear;
   assign dataOut       = dOut_reg;
   assign dataOe_n      = driveNow ? '0 : '1;
   assign strobeOut     = {dsp_pkg::LANES{stbLvl_reg}};
   assign strobeCompOut = {dsp_pkg::LANES{!stbLvl_reg}};
   assign strobeOe_n    = driveNow ? '0 : '1;

   // a pair that is not complementary during a write means single-ended use
   logic fault_reg;
   always_ff @(posedge core_clk) begin
      if (inClear) begin
         fault_reg <= 1'b0;
      end else if (state_reg == ST_WRITE && (|(stb_reg & stbc_reg) ||
                   |(~stb_reg & ~stbc_reg))) begin
         fault_reg <= 1'b1;
      end
   end
   assign strobeFault = fault_reg;

   // ----------------------------------------
   // termination
   // ----------------------------------------
   logic odt_reg;
   always_ff @(posedge core_clk) begin
      if (inClear) begin
         odt_reg <= 1'b0;
      end else begin
         odt_reg <= dieTerminationCtl;
      end
   end
   // termination drops while reading so the memory never loads its own drive
   assign dataTermEn         = odt_reg && termEnabled && !inClear && !driving_reg;
   assign termStrobeTermEn   = dataTermEn && termMode;
   assign termStrobeCompUsed = termMode;
   assign inputPinTermEn     = 1'b0;
endmodule : dsp_pins
`default_nettype wire

// ### testbench/dsp_pins_props.sv
// Purpose: pin assertions for dsp_pins
// Assumes: bound from the bench top
// Notes:   read drive lasts 16 cycles
`timescale 1ns/1ns
`default_nettype none
module dsp_pins_props (
   // watched pins
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        clearPin_n,
   input wire logic [15:0] modeRegOne,
   input wire logic        dieTerminationCtl,
   input wire logic [15:0] dataOe_n,
   input wire logic [1:0]  strobeOut,
   input wire logic [1:0]  strobeCompOut,
   input wire logic [1:0]  strobeOe_n,
   input wire logic        termStrobeTermEn,
   input wire logic        termStrobeCompUsed,
   input wire logic        dataTermEn,
   input wire logic        inputPinTermEn,
   input wire logic        inReset
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_clr;
      !clearPin_n |-> inReset && &dataOe_n && &strobeOe_n && !dataTermEn;
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");
   property p_dif; &(strobeOe_n | (strobeOut ^ strobeCompOut)); endproperty
   a_dif: assert property (p_dif) else $error("strobe pair equal");
   property p_tog; !strobeOe_n[0] && !$past(strobeOe_n[0]) |-> $changed(strobeOut[0]); endproperty
   a_tog: assert property (p_tog) else $error("strobe stuck");
   property p_idl; &strobeOe_n |-> &dataOe_n; endproperty
   a_idl: assert property (p_idl) else $error("data driven idle");
   property p_len; $fell(dataOe_n[0]) |-> (!dataOe_n[0]) [*8]; endproperty
   a_len: assert property (p_len) else $error("read drive short");
   property p_ts; termStrobeTermEn == (modeRegOne[11] && dataTermEn); endproperty
   a_ts: assert property (p_ts) else $error("term strobe wrong");
   property p_cu; !modeRegOne[11] |-> !termStrobeCompUsed && !inputPinTermEn; endproperty
   a_cu: assert property (p_cu) else $error("pin term wrong");
   property p_odt; dataTermEn |-> $past(dieTerminationCtl); endproperty
   a_odt: assert property (p_odt) else $error("term not registered");
endmodule : dsp_pins_props
`default_nettype wire

// ### testbench/dsp_ctrl_model.sv
// Purpose: controller side of data, strobe and mask pins
// Assumes: bench calls one task at a time
// Notes:   strobe stands still between bursts
`timescale 1ns/1ns
`default_nettype none
module dsp_ctrl_model (
   // pins
   input  wire logic        core_clk,
   output var  logic        readReq,
   output var  logic        writeReq,
   output var  logic [3:0]  burstAddr,
   output var  logic [15:0] dataDrv,
   output var  logic [1:0]  strobeDrv,
   output var  logic [1:0]  writeBeatMask
);
   initial begin
      {readReq, writeReq, burstAddr, strobeDrv, writeBeatMask} = '0;
      dataDrv = 16'h5a5a;
   end
   task automatic req(input logic rd, input logic [3:0] a);
      @(posedge core_clk);
      readReq <= rd;
      writeReq <= !rd;
      burstAddr <= a;
      @(posedge core_clk);
      readReq <= 1'b0;
      writeReq <= 1'b0;
   endtask : req
   // data leads each strobe edge by two cycles so the edge is centred
   task automatic wr(input logic [15:0] d [8], input logic [1:0] m [8]);
      for (int n = 0; n < 8; n++) begin
         dataDrv <= d[n];
         writeBeatMask <= m[n];
         repeat (2) @(posedge core_clk);
         strobeDrv <= ~strobeDrv;
         repeat (2) @(posedge core_clk);
      end
      dataDrv <= ~d[7]; // released bus must not show a stale value
   endtask : wr
endmodule : dsp_ctrl_model
`default_nettype wire

// ### testbench/dsp_pins_tb_top.sv
// Purpose: self-checking bench for dsp_pins
// Assumes: model drives requests and write bursts, bench the rest
// Notes:   each read beat stands two cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk((g) === (e))
module dsp_pins_tb_top;
   logic core_clk = 1'b0, rst_n = 1'b0, clearPin_n = 1'b1, termEnabled = 1'b0;
   logic dieTerminationCtl = 1'b0, readReq, writeReq, inReset;
   logic termStrobeTermEn, termStrobeCompUsed, dataTermEn, inputPinTermEn;
   logic strobeFault, singleEnded = 1'b0;
   logic [15:0] modeRegOne = 16'h0000, dataIn, dataOut, dataOe_n, dataDrv;
   logic [15:0] mem [16];
   logic [3:0]  burstAddr;
   logic [1:0]  strobeIn, strobeCompIn, strobeOut, strobeCompOut, strobeOe_n, strobeDrv;
   logic [1:0]  writeBeatMask;
   int          errors = 0, compares = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   // wires resolved from the dsp_pins output enables; the model drives whenever they are off
   assign dataIn = (dataOe_n & dataDrv) | (~dataOe_n & dataOut);
   assign strobeIn = (strobeOe_n & strobeDrv) | (~strobeOe_n & strobeOut);
   // singleEnded ties the complement to the true strobe, as a broken board would
   assign strobeCompIn = (strobeOe_n & (singleEnded ? strobeDrv : ~strobeDrv)) |
      (~strobeOe_n & strobeCompOut);
   dsp_pins u_dsp_pins (.core_clk, .rst_n, .clearPin_n, .modeRegOne, .termEnabled,
      .dieTerminationCtl, .readReq, .writeReq, .burstAddr, .dataIn, .dataOut, .dataOe_n,
      .strobeIn, .strobeCompIn, .strobeOut, .strobeCompOut, .strobeOe_n, .writeBeatMask,
      .termStrobeTermEn, .termStrobeCompUsed, .dataTermEn, .inputPinTermEn, .inReset,
      .strobeFault);
   dsp_ctrl_model u_dsp_ctrl_model (.core_clk, .readReq, .writeReq, .burstAddr, .dataDrv,
      .strobeDrv, .writeBeatMask);
   task automatic chk(input bit ok);
      compares++;
      if (!ok) begin
         errors++;
         $display("wrong value at %0t: compare %0d", $time, compares);
      end
   endtask : chk
   task automatic end_sim();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   // expected word after one beat: masked lanes keep the old byte, term mode ignores mask
   function automatic logic [15:0] exp_word(input logic [15:0] old, input logic [15:0] d,
                                            input logic [1:0] m, input logic term);
      return term ? d : {m[1] ? old[15:8] : d[15:8], m[0] ? old[7:0] : d[7:0]};
   endfunction : exp_word
   // write a burst, then read it back and match every beat
   task automatic burst(input logic [3:0] a, input bit masked);
      logic [15:0] d [8];
      logic [1:0]  m [8];
      logic [15:0] q [$];
      logic [3:0]  ix;
      for (int n = 0; n < 8; n++) begin
         d[n] = 16'($urandom);
         m[n] = masked ? 2'($urandom) : 2'h0;
         ix = a + 4'(n);
         mem[ix] = exp_word(mem[ix], d[n], m[n], modeRegOne[11]);
      end
      u_dsp_ctrl_model.req(1'b0, a);
      u_dsp_ctrl_model.wr(d, m);
      repeat (8) @(posedge core_clk);
      u_dsp_ctrl_model.req(1'b1, a);
      for (int i = 0; i < 40 && q.size() < 16; i++) begin
         @(posedge core_clk);
         #1 if (dataOe_n === 16'h0000) q.push_back(dataOut);
      end
      `CHK(q.size(), 16);
      for (int n = 0; n < 8; n++) begin
         ix = a + 4'(n);
         `CHK(q[2*n] === mem[ix] && q[2*n+1] === mem[ix], 1'b1);
      end
      repeat (3) @(posedge core_clk);
   endtask : burst
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'hf2e5));
      repeat (3) @(posedge core_clk);
      `CHK({inReset, strobeOe_n}, 3'h7);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      burst(4'hf, 1'b0);
      burst(4'h7, 1'b0);
      repeat (3) burst(4'($urandom), 1'b1);
      modeRegOne <= 16'h0800;
      termEnabled <= 1'b1;
      dieTerminationCtl <= 1'b1;
      // let the new mode land before the expectations read it
      @(posedge core_clk);
      burst(4'h3, 1'b1);
      `CHK({termStrobeTermEn, termStrobeCompUsed, dataTermEn, inputPinTermEn}, 4'he);
      modeRegOne <= 16'h0000;
      dieTerminationCtl <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 `CHK({termStrobeTermEn, termStrobeCompUsed, dataTermEn}, 3'h0);
      `CHK(strobeFault, 1'b0);
      @(posedge core_clk);
      clearPin_n <= 1'b0;
      #1 `CHK(inReset, 1'b1);
      @(posedge core_clk);
      clearPin_n <= 1'b1;
      @(posedge core_clk);
      #1 `CHK(inReset, 1'b1);
      repeat (2) @(posedge core_clk);
      singleEnded <= 1'b1;
      #1 `CHK(inReset, 1'b0);
      burst(4'h5, 1'b0);
      `CHK(strobeFault, 1'b1);
      end_sim();
   end
endmodule : dsp_pins_tb_top
bind dsp_pins dsp_pins_props u_dsp_pins_props (.core_clk, .rst_n, .clearPin_n, .modeRegOne,
   .dieTerminationCtl, .dataOe_n, .strobeOut, .strobeCompOut, .strobeOe_n,
   .termStrobeTermEn, .termStrobeCompUsed, .dataTermEn, .inputPinTermEn, .inReset);
`default_nettype wire
